// File: rtl/loop_two_defines.svh
// Constants for the loopback-two relay and loop control block.
`ifndef LOOP_TWO_DEFINES_SVH
`define LOOP_TWO_DEFINES_SVH
`define CMD_W 4
`define CMD_AR 4'h8
`define CMD_ARL 4'ha
`define CMD_AI 4'hc
`define CMD_AIL 4'he
`define CMD_RSY 4'h4
`define CMD_TIM 4'h0
`define ZERO_FRAMES 3'h4
`define ECHO_LOOPED 1'b0
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// File: rtl/loop_two_pkg.sv
// Types shared by the loopback-two relay block.
`default_nettype none
package loop_two_pkg;
    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [1:0] d;
    } frame_t;
    typedef enum logic [1:0] {
        line_idle,
        line_pending,
        line_transparent
    } line_state_t;
endpackage
`default_nettype wire

// File: rtl/frame_fifo.sv
// Parameterised valid/ready FIFO for looped frames.
`default_nettype none
module frame_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = wr_valid_in && wr_ready_out;
    wire pop = rd_valid_out && rd_ready_in;
    assign wr_ready_out = (count_reg != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_reg != '0);
    assign rd_data_out = mem[rd_ptr_reg];
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= wr_data_in;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// File: rtl/loop_two_relay.sv
// Loopback-two relay: line-side command forwarding and user-side complete loop.
// Functional notes
// - Loops one, one-A, two come from exchange; loop three is local.
// - Looped bits also continue onward unchanged; loops are transparent.
// - While looped, physical receive data on the looped side is ignored.
// - Bearer and signalling data share one identical loop delay.
// - Loop two loops both bearer channels and signalling in user transceiver.
// - Request in transparent state is forwarded as looped activation indication.
// - Request in other states is forwarded as looped activation request.
// - Loop change resync: user sends resync then indication; line repeats indication.
// - Exchange wake signal starts before terminator activation signal.
// - User side closes loop on looped indication or looped request.
// - Echo bit forced to zero during loop two.
// - After looped indication, zeros loop back upstream for four frames; code sends them only if the loop was still open.
`default_nettype none
`include "loop_two_defines.svh"
module loop_two_relay (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic frame_tick_in,
    input wire logic maint_loop_req_in,
    input wire logic line_synced_in,
    input wire logic line_transparent_in,
    input wire logic exchange_wake_signal_in,
    output logic terminator_activation_signal_out,
    output logic [`CMD_W-1:0] downstream_command_channel_out,
    input wire logic [`CMD_W-1:0] upstream_command_channel_in,
    input wire logic resync_needed_in,
    input wire loop_two_pkg::frame_t bus_rx_in,
    input wire loop_two_pkg::frame_t exch_tx_in,
    output loop_two_pkg::frame_t bus_tx_out,
    output loop_two_pkg::frame_t upstream_out,
    output logic upstream_valid_out,
    input wire logic upstream_ready_in,
    output logic echo_bit_out,
    input wire logic echo_in,
    output logic loop_closed_out
);
    loop_two_pkg::line_state_t line_state_next;
    logic [`CMD_W-1:0] cmd_reg, cmd_next;
    logic [`CMD_W-1:0] user_cmd_reg, user_cmd_prev_reg;
    logic loop_reg;
    logic [2:0] zero_cnt_reg;
    logic resync_pend_reg;
    logic act_reg;
    loop_two_pkg::frame_t bus_tx_reg;
    logic echo_reg;
    wire fifo_wr_ready;

    // Line transceiver state follows the line's synchronisation progress.
    always_comb
    begin
        line_state_next = loop_two_pkg::line_idle;
        if (line_transparent_in)
            line_state_next = loop_two_pkg::line_transparent;
        else if (line_synced_in)
            line_state_next = loop_two_pkg::line_pending;
    end

    // Maps the line state and the maintenance request onto the downstream code.
    function automatic logic [`CMD_W-1:0] relay_cmd(input loop_two_pkg::line_state_t st,
                                                      input logic loop_req);
        logic [`CMD_W-1:0] c;
        c = `CMD_TIM;
        case (st)
            loop_two_pkg::line_transparent:
            begin
                if (loop_req)
                    c = `CMD_AIL;
                else
                    c = `CMD_AI;
            end
            loop_two_pkg::line_pending:
            begin
                if (loop_req)
                    c = `CMD_ARL;
                else
                    c = `CMD_AR;
            end
            loop_two_pkg::line_idle:
            begin
                // Nothing is announced downstream yet unless the exchange wants a loop.
                if (loop_req)
                    c = `CMD_ARL;
                else
                    c = `CMD_TIM;
            end
            default:
            begin
                c = `CMD_TIM;
            end
        endcase
        return c;
    endfunction

    // The maintenance channel request is the only loop source.
    assign cmd_next = relay_cmd(line_state_next, maint_loop_req_in);

    wire user_sent_resync = (user_cmd_prev_reg == `CMD_RSY);
    wire user_sent_ai = (user_cmd_reg == `CMD_AI);
    wire cmd_is_ail = (cmd_reg == `CMD_AIL);
    wire cmd_is_arl = (cmd_reg == `CMD_ARL);
    wire loop_next = cmd_is_ail || cmd_is_arl;
    wire loop_change = loop_next != loop_reg;

    // Line side: drive the activation signal only once the wake signal is seen.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            cmd_reg <= `CMD_TIM;
            act_reg <= 1'b0;
        end
        else
        begin
            cmd_reg <= cmd_next;
            act_reg <= exchange_wake_signal_in && line_synced_in;
        end
    end

    // The user side's codes are kept for two cycles so that the resync sequence
    // is recognised as the resync code followed directly by the indication.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            user_cmd_reg <= `CMD_TIM;
            user_cmd_prev_reg <= `CMD_TIM;
            resync_pend_reg <= 1'b0;
        end
        else
        begin
            user_cmd_reg <= upstream_command_channel_in;
            user_cmd_prev_reg <= user_cmd_reg;
            if (loop_change && resync_needed_in)
                resync_pend_reg <= 1'b1;
            else if (user_sent_resync && user_sent_ai)
                resync_pend_reg <= 1'b0;
        end
    end

    // After a resync the indication is simply repeated; cmd_reg keeps it on the channel.
    assign downstream_command_channel_out = cmd_reg;
    assign terminator_activation_signal_out = act_reg;

    // Frames offered during a resync are dropped. A zero frame only counts once the
    // buffer has taken it, otherwise a drop would shorten the run of zero frames.
    wire loop_frame_source_zero = (zero_cnt_reg != 3'h0);
    wire up_valid = frame_tick_in && !resync_pend_reg;
    wire zero_frame_sent = up_valid && fifo_wr_ready && loop_frame_source_zero;

    // User side loop control and the four zero frames when a looped indication closes the loop.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            loop_reg <= 1'b0;
            zero_cnt_reg <= 3'h0;
        end
        else
        begin
            loop_reg <= loop_next;
            if (cmd_is_ail && !loop_reg)
                zero_cnt_reg <= `ZERO_FRAMES;
            else if (zero_frame_sent)
                zero_cnt_reg <= zero_cnt_reg - 3'h1;
        end
    end

    // Looped frames ride one path so bearer and signalling share a delay.
    wire loop_two_pkg::frame_t up_src = loop_reg ? exch_tx_in : bus_rx_in;
    logic [$bits(loop_two_pkg::frame_t)-1:0] up_bits;
    for (genvar g = 0; g < $bits(loop_two_pkg::frame_t); g++)
    begin : g_up_bits
        assign up_bits[g] = loop_frame_source_zero ? 1'b0 : up_src[g];
    end
    wire loop_two_pkg::frame_t up_word = up_bits;

    // Onward data always passes, looped or not, so the loop stays transparent.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            bus_tx_reg <= '0;
        end
        else
        begin
            bus_tx_reg <= exch_tx_in;
        end
    end

    // Echo idles high after reset so the user side does not see a false low bit.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            echo_reg <= 1'b1;
        end
        else
        begin
            echo_reg <= loop_reg ? `ECHO_LOOPED : echo_in;
        end
    end

    assign bus_tx_out = bus_tx_reg;
    assign echo_bit_out = echo_reg;
    assign loop_closed_out = loop_reg;

    frame_fifo #(
        .WIDTH($bits(loop_two_pkg::frame_t)),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_data_in(up_word),
        .wr_valid_in(up_valid),
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(upstream_out),
        .rd_valid_out(upstream_valid_out),
        .rd_ready_in(upstream_ready_in)
    );
endmodule
`default_nettype wire

// File: test/loop_two_relay_properties.sv
// Port-level checks for the loopback-two relay.
`default_nettype none
module loop_two_relay_properties (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic maint_loop_req_in,
    input wire logic line_synced_in,
    input wire logic line_transparent_in,
    input wire logic exchange_wake_signal_in,
    input wire logic terminator_activation_signal_out,
    input wire logic [3:0] downstream_command_channel_out,
    input wire loop_two_pkg::frame_t exch_tx_in,
    input wire loop_two_pkg::frame_t bus_tx_out,
    input wire loop_two_pkg::frame_t upstream_out,
    input wire logic upstream_valid_out,
    input wire logic upstream_ready_in,
    input wire logic echo_bit_out,
    input wire logic loop_closed_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
a_ind_looped: assert property (maint_loop_req_in && line_transparent_in
    |=> downstream_command_channel_out == 4'he) else $error("looped indication missing");
a_req_looped: assert property (maint_loop_req_in && !line_transparent_in
    |=> downstream_command_channel_out == 4'ha) else $error("looped request missing");
a_plain_ind: assert property (!maint_loop_req_in && line_transparent_in
    |=> downstream_command_channel_out == 4'hc) else $error("plain indication missing");
a_echo_zero: assert property (loop_closed_out |=> !echo_bit_out)
    else $error("echo bit not forced low");
a_wake_order: assert property (terminator_activation_signal_out
    |-> $past(exchange_wake_signal_in) && $past(line_synced_in)) else $error("early activation");
a_bus_pass: assert property ($past(rst_n_in) |-> bus_tx_out == $past(exch_tx_in))
    else $error("onward data altered");
a_loop_close: assert property (maint_loop_req_in [*2] |=> loop_closed_out)
    else $error("loop not closed");
a_loop_open: assert property (!maint_loop_req_in [*2] |=> !loop_closed_out)
    else $error("loop not opened");
a_fifo_hold: assert property (upstream_valid_out && !upstream_ready_in
    |=> upstream_valid_out && $stable(upstream_out)) else $error("stalled frame lost");
endmodule
`default_nettype wire

// File: test/user_side_model.sv
// Behavioural user-side bus transceiver facing the relay.
`default_nettype none
module user_side_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic loop_in,
    input wire logic slow_in,
    output logic [3:0] cmd_out,
    output logic ready_out
);
timeunit 1ns;
timeprecision 1ps;
logic loop_reg = 1'b0;
logic rsy_reg = 1'b0;
logic tog_reg = 1'b0;
// A loop change costs one cycle of resync before the indication returns.
assign cmd_out = rsy_reg ? 4'h4 : 4'hc;
// A slow partner accepts only every other cycle, so the buffer must hold.
assign ready_out = ~slow_in | tog_reg;
always_ff @(posedge clk_in)
begin
    loop_reg <= rst_n_in & loop_in;
    rsy_reg <= rst_n_in & (loop_in != loop_reg);
    tog_reg <= ~tog_reg;
end
endmodule
`default_nettype wire

// File: test/loop_two_relay_tb_top.sv
// Self-checking testbench for the loopback-two relay.
`default_nettype none
module loop_two_relay_tb_top;
timeunit 1ns;
timeprecision 1ps;
logic clk_in = 0, rst_n_in = 0, tick = 0, req = 0, sync = 0, trans = 0, wake = 0;
logic resync = 0, echo = 1, slow = 0, act, valid, ready, echo_o, closed;
logic [3:0] dn, up;
loop_two_pkg::frame_t rx = '0, tx = '0, btx, uo;
loop_two_pkg::frame_t got[$];
int errors = 0, checked = 0, cyc = 0;
always #20 clk_in = ~clk_in;
loop_two_relay u_loop_two_relay (.clk_in, .rst_n_in, .frame_tick_in(tick),
    .maint_loop_req_in(req), .line_synced_in(sync), .line_transparent_in(trans),
    .exchange_wake_signal_in(wake), .terminator_activation_signal_out(act),
    .downstream_command_channel_out(dn), .upstream_command_channel_in(up),
    .resync_needed_in(resync), .bus_rx_in(rx), .exch_tx_in(tx), .bus_tx_out(btx),
    .upstream_out(uo), .upstream_valid_out(valid), .upstream_ready_in(ready),
    .echo_bit_out(echo_o), .echo_in(echo), .loop_closed_out(closed));
user_side_model u_user_side_model (.clk_in, .rst_n_in, .loop_in(closed), .slow_in(slow),
    .cmd_out(up), .ready_out(ready));
always @(posedge clk_in)
begin
    cyc++;
    if (valid === 1'b1 && ready === 1'b1)
        got.push_back(uo);
    if (cyc == 3000)
    begin
        errors++;
        finish_test();
    end
end
task chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp)
    begin
        errors++;
        $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
endtask
task finish_test;
    if (errors == 0 && checked > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
task step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
endtask
task t_wake;
    wake = 1;
    step(1);
    chk(act, 0);
    sync = 1;
    step(2);
    chk(act, 1);
    wake = 0;
    step(2);
    chk(act, 0);
endtask
task t_codes;
    trans = 1;
    req = 1;
    step(1);
    chk(dn, 4'he);
    trans = 0;
    step(1);
    chk(dn, 4'ha);
    sync = 0;
    step(1);
    chk(dn, 4'ha);
    req = 0;
    trans = 1;
    step(1);
    chk(dn, 4'hc);
    step(4);
endtask
// Junk on the bus receive side must never reach the upstream path.
task t_loop;
    resync = 1;
    slow = 1;
    rx = '1;
    req = 1;
    step(3);
    chk(closed, 1);
    chk(echo_o, 0);
    // A frame offered during the resync is dropped and must not use up a zero frame.
    tick = 1;
    step(1);
    tick = 0;
    step(3);
    chk(valid, 0);
    chk(dn, 4'he);
    for (int i = 1; i <= 8; i++)
    begin
        tx = {i[7:0], ~i[7:0], i[1:0]};
        step(1);
        tick = 1;
        step(1);
        tick = 0;
        step(2);
    end
    for (int n = 0; n < 100 && got.size() < 8; n++)
        step(1);
    chk(got.size(), 8);
    for (int i = 0; i < 4; i++)
        chk(got[i], '0);
    for (int i = 5; i <= 8; i++)
        chk(got[i-1], {i[7:0], ~i[7:0], i[1:0]});
    chk(btx, tx);
    req = 0;
    step(3);
    chk(closed, 0);
    chk(echo_o, 1);
    echo = 0;
    step(1);
    chk(echo_o, 0);
endtask
initial
begin
    step(20);
    rst_n_in = 1;
    t_wake();
    t_codes();
    t_loop();
    finish_test();
end
endmodule
bind loop_two_relay loop_two_relay_properties u_loop_two_relay_properties (.clk_in,
    .rst_n_in, .maint_loop_req_in, .line_synced_in, .line_transparent_in,
    .exchange_wake_signal_in, .terminator_activation_signal_out,
    .downstream_command_channel_out, .exch_tx_in, .bus_tx_out, .upstream_out,
    .upstream_valid_out, .upstream_ready_in, .echo_bit_out, .loop_closed_out);
`default_nettype wire
